/* File: hw/pfs_pkg.sv */
// Purpose: Shared constants and types of the PFC protection and flyback sensing block
// Assumes: 100 MHz clock, ADC codes delivered on the same clock
// Notes: Register map is word aligned on a plain strobe port
`default_nettype none
package pfs_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
   localparam int SH_DEPTH = 4;
   // Fault indices, blanked ones first
   localparam int NB = 10;
   localparam int NF = 11;
   localparam int F_BUS_UV = 0;
   localparam int F_BUS_OV1 = 1;
   localparam int F_BUS_OV2 = 2;
   localparam int F_IN_UV = 3;
   localparam int F_IN_OV = 4;
   localparam int F_SECOND_LEVEL_OVERCURRENT = 5;
   localparam int F_CCM = 6;
   localparam int F_OUT_OV = 7;
   localparam int F_OUT_UV = 8;
   localparam int F_OUT_OC = 9;
   localparam int F_SS = 10;
   // Configuration word indices
   localparam int NCFG = 30;
   localparam int C_BUS_UV = 0;
   localparam int C_BUS_OV1 = 1;
   localparam int C_BUS_REENTRY = 2;
   localparam int C_IN_UV = 3;
   localparam int C_IN_OV = 4;
   localparam int C_START_MIN = 5;
   localparam int C_START_MAX = 6;
   localparam int C_OUT_OV = 7;
   localparam int C_OUT_UV = 8;
   localparam int C_OUT_OC = 9;
   localparam int C_BLANK0 = 10;
   localparam int C_SS_MAX = 20;
   localparam int C_FIRST_LEVEL_OVERCURRENT = 21;
   localparam int C_PDC = 22;
   localparam int C_CSOFF = 23;
   localparam int C_RECIP = 24;
   localparam int C_VGAIN = 25;
   localparam int C_VOFF = 26;
   localparam int C_IGAIN = 27;
   localparam int C_NPULSE = 28;
   localparam int C_TBURST = 29;
   // Fixed levels
   localparam logic [11:0] BUS_VREF_CODE = 12'h0c00;
   localparam logic [11:0] BUS_OV2_CODE = 12'(BUS_VREF_CODE * 7 / 6);
   localparam logic [9:0] PFC_SECOND_LEVEL_OVERCURRENT_CODE = 10'h3c0;
   // Register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FAULT = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_VOUT = 8'h0c;
   localparam logic [7:0] A_IOUT = 8'h10;
   localparam logic [7:0] A_IPK = 8'h14;
   localparam logic [7:0] A_CFG_BASE = 8'h40;
   // Reset values
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [3:0] VDLY_RST = 4'h2;

   typedef enum logic [1:0] {
      MODE_FIRST = 2'b00,
      MODE_DELAYED = 2'b01,
      MODE_BURST = 2'b10
   } pfs_mode_e;

   typedef enum logic [1:0] {
      FB_IDLE = 2'b00,
      FB_ON = 2'b01,
      FB_DEMAG = 2'b10,
      FB_RING = 2'b11
   } pfs_fb_e;

   typedef struct packed {
      logic [11:0] bus_sense_input;
      logic [11:0] line_sense_input;
      logic [9:0] pfc_current_sense_input;
      logic [9:0] flyback_current_sense_input;
      logic [9:0] valley_detect_input;
   } pfs_samp_s;

   typedef struct packed {
      logic [15:0] vout;
      logic [15:0] iout;
      logic vout_valid;
      logic iout_valid;
   } pfs_meas_s;

   typedef struct packed {
      logic en;
      pfs_mode_e mode;
      logic [3:0] vdly;
      logic [NF-1:0] flags;
      logic [NB-1:0][15:0] cnt;
      logic [NCFG-1:0][15:0] cfg;
      logic [6:0] pre;
      logic tick;
      logic pfc_stop;
      logic start_ok;
      logic ss_active;
      logic [15:0] ss_cnt;
      logic [2:0] pv;
      logic [2:0] fv;
      logic seen_valley;
      logic miss_ring;
      logic [7:0] ccm_ev;
      pfs_fb_e st;
      logic armed;
      logic gate;
      logic [3:0] vcnt;
      logic [SH_DEPTH-1:0][9:0] dly;
      logic [9:0] vcs_sh;
      logic [15:0] ton;
      logic [15:0] tdm;
      logic [15:0] tdm_last;
      logic [15:0] tsw;
      logic [15:0] ipk;
      pfs_meas_s meas;
      logic [31:0] rdata;
   } pfs_state_s;
endpackage
`default_nettype wire

/* File: hw/pfs_top.sv */
// Purpose: PFC protection monitor and flyback primary-side sensing
// Assumes: Samples and event pulses come from logic on clock; comparator pins are async
// Notes: Fault flags are sticky, cleared by register write-one or by fault_clr
`default_nettype none
module pfs_top import pfs_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Samples and comparator pins
   input wire pfs_samp_s samp,
   input wire logic pfc_valley_cmp,
   input wire logic fb_valley_cmp,
   // PFC events
   input wire logic pfc_turn_on,
   input wire logic pfc_timeout_on,
   input wire logic ss_begin,
   input wire logic ss_end,
   // Flyback control
   input wire logic fb_turn_on_req,
   // Fault handling
   input wire logic [NF-1:0] fault_clr,
   output logic [NF-1:0] fault_flags,
   output logic pfc_stop,
   output logic fb_start_ok,
   // Flyback results
   output logic fb_gate,
   output logic [9:0] fb_first_level_overcurrent_level,
   output var pfs_meas_s meas
);
   pfs_state_s s_reg;
   pfs_state_s s_next;
   logic [NB-1:0] cond;
   logic [NB-1:0] fire;

   always_comb begin
      pfs_state_s n;
      logic [NF-1:0] clr;
      logic ss_fail;
      logic [5:0] cidx;
      logic cfg_hit;
      logic [3:0] tgt;
      logic [63:0] num;
      logic [63:0] den;
      logic fb_rise;
      logic fb_fall;
      n = s_reg;
      clr = fault_clr;
      ss_fail = 1'b0;
      cidx = 6'((reg_addr - A_CFG_BASE) >> 2);
      cfg_hit = reg_addr >= A_CFG_BASE && reg_addr[1:0] == 2'b00 && cidx < 6'(NCFG);
      tgt = 4'h1;
      num = 64'h0000_0000_0000_0000;
      den = 64'h0000_0000_0000_0000;
      fb_rise = s_reg.fv[1] && !s_reg.fv[2];
      fb_fall = !s_reg.fv[1] && s_reg.fv[2];
      n.tick = 1'b0;
      n.meas.vout_valid = 1'b0;
      n.meas.iout_valid = 1'b0;
      n.rdata = 32'h0000_0000;

      // Microsecond tick for blanking and soft start
      if (s_reg.pre == TICK_LAST) begin
         n.pre = 7'h00;
         n.tick = 1'b1;
      end else begin
         n.pre = s_reg.pre + 7'h01;
      end

      // Comparator synchronisers
      n.pv = {s_reg.pv[1:0], pfc_valley_cmp};
      n.fv = {s_reg.fv[1:0], fb_valley_cmp};

      // Register writes
      if (reg_wr) begin
         if (reg_addr == A_CTRL) begin
            n.en = reg_wdata[0];
            n.mode = pfs_mode_e'(reg_wdata[2:1]);
            n.vdly = reg_wdata[7:4];
         end
         if (reg_addr == A_FAULT) begin
            clr = clr | reg_wdata[NF-1:0];
         end
         if (cfg_hit) begin
            n.cfg[cidx] = reg_wdata[15:0];
         end
      end

      // Register reads, data one cycle later
      if (reg_rd) begin
         if (reg_addr == A_CTRL) begin
            n.rdata = {24'h00_0000, s_reg.vdly, 1'b0, s_reg.mode, s_reg.en};
         end else if (reg_addr == A_FAULT) begin
            n.rdata = 32'(s_reg.flags);
         end else if (reg_addr == A_STATUS) begin
            n.rdata = {16'h0000, s_reg.ccm_ev, 2'b00, s_reg.st, s_reg.gate,
                       s_reg.ss_active, s_reg.start_ok, s_reg.pfc_stop};
         end else if (reg_addr == A_VOUT) begin
            n.rdata = {16'h0000, s_reg.meas.vout};
         end else if (reg_addr == A_IOUT) begin
            n.rdata = {16'h0000, s_reg.meas.iout};
         end else if (reg_addr == A_IPK) begin
            n.rdata = {16'h0000, s_reg.ipk};
         end else if (cfg_hit) begin
            n.rdata = {16'h0000, s_reg.cfg[cidx]};
         end
      end

      // Ringing watch on the PFC valley pin
      if (pfc_turn_on) begin
         n.seen_valley = 1'b0;
      end
      if (s_reg.pv[1] && !s_reg.pv[2]) begin
         n.seen_valley = 1'b1;
         n.miss_ring = 1'b0;
      end
      if (pfc_timeout_on && !s_reg.seen_valley) begin
         n.miss_ring = 1'b1;
         n.ccm_ev = s_reg.ccm_ev + 8'h01;
      end

      // Soft start timer
      if (ss_begin) begin
         n.ss_active = 1'b1;
         n.ss_cnt = 16'h0000;
      end else if (s_reg.ss_active) begin
         if (ss_end) begin
            n.ss_active = 1'b0;
         end else if (s_reg.ss_cnt >= s_reg.cfg[C_SS_MAX]) begin
            ss_fail = s_reg.en;
            n.ss_active = 1'b0;
         end else if (s_reg.tick) begin
            n.ss_cnt = s_reg.ss_cnt + 16'h0001;
         end
      end

      // Fault conditions
      cond[F_BUS_UV] = samp.bus_sense_input < s_reg.cfg[C_BUS_UV][11:0];
      cond[F_BUS_OV1] = samp.bus_sense_input > s_reg.cfg[C_BUS_OV1][11:0];
      cond[F_BUS_OV2] = samp.bus_sense_input >= BUS_OV2_CODE;
      cond[F_IN_UV] = samp.line_sense_input < s_reg.cfg[C_IN_UV][11:0];
      cond[F_IN_OV] = samp.line_sense_input > s_reg.cfg[C_IN_OV][11:0];
      cond[F_SECOND_LEVEL_OVERCURRENT] = samp.pfc_current_sense_input >= PFC_SECOND_LEVEL_OVERCURRENT_CODE;
      cond[F_CCM] = s_reg.miss_ring && !s_reg.ss_active;
      cond[F_OUT_OV] = s_reg.start_ok && s_reg.meas.vout > s_reg.cfg[C_OUT_OV];
      cond[F_OUT_UV] = s_reg.start_ok && s_reg.meas.vout < s_reg.cfg[C_OUT_UV];
      cond[F_OUT_OC] = s_reg.start_ok && s_reg.meas.iout > s_reg.cfg[C_OUT_OC];

      // Blanking timers
      for (int i = 0; i < NB; i++) begin
         cond[i] = cond[i] && s_reg.en;
         fire[i] = s_reg.cnt[i] > s_reg.cfg[C_BLANK0 + i];
         if (!cond[i]) begin
            n.cnt[i] = 16'h0000;
         end else if (s_reg.tick && !fire[i] && s_reg.cnt[i] != 16'hffff) begin
            n.cnt[i] = s_reg.cnt[i] + 16'h0001;
         end
         fire[i] = fire[i] && cond[i];
      end

      // Sticky flags, set beats clear
      n.flags = (s_reg.flags & ~clr) | {ss_fail, fire};

      // PFC stop and resume
      if (fire[F_BUS_OV1]) begin
         n.pfc_stop = 1'b1;
      end else if (samp.bus_sense_input < s_reg.cfg[C_BUS_REENTRY][11:0]) begin
         n.pfc_stop = 1'b0;
      end

      // Second stage start window
      if (fire[F_IN_UV] || fire[F_IN_OV] || !s_reg.en) begin
         n.start_ok = 1'b0;
      end else if (samp.line_sense_input >= s_reg.cfg[C_START_MIN][11:0] &&
                   samp.line_sense_input <= s_reg.cfg[C_START_MAX][11:0]) begin
         n.start_ok = 1'b1;
      end

      // Flyback sense history for the pre-turn-off sample
      n.dly = {s_reg.dly[SH_DEPTH-2:0], samp.flyback_current_sense_input};
      if (fb_turn_on_req) begin
         n.armed = 1'b1;
      end
      if (s_reg.tsw != 16'hffff) begin
         n.tsw = s_reg.tsw + 16'h0001;
      end
      if (s_reg.mode == MODE_DELAYED) begin
         tgt = (s_reg.vdly < 4'h2) ? 4'h2 : s_reg.vdly;
      end

      // Flyback switching cycle
      case (s_reg.st)
         FB_IDLE: begin
            if (s_reg.armed && s_reg.en) begin
               n.st = FB_ON;
               n.gate = 1'b1;
               n.armed = 1'b0;
               n.ton = 16'h0000;
               n.tsw = 16'h0000;
            end
         end
         FB_ON: begin
            n.ton = s_reg.ton + 16'h0001;
            if (samp.flyback_current_sense_input >= s_reg.cfg[C_FIRST_LEVEL_OVERCURRENT][9:0] || !s_reg.en) begin
               n.gate = 1'b0;
               n.st = FB_DEMAG;
               n.tdm = 16'h0000;
               n.vcs_sh = s_reg.dly[SH_DEPTH-1];
               num = 64'(s_reg.dly[SH_DEPTH-1]) * 64'(s_reg.cfg[C_RECIP]) *
                     (64'(s_reg.ton) + 64'(s_reg.cfg[C_PDC]));
               if (s_reg.ton > s_reg.cfg[C_CSOFF]) begin
                  den = 64'(s_reg.ton - s_reg.cfg[C_CSOFF]);
                  n.ipk = 16'((num / den) >> 8);
               end else begin
                  n.ipk = 16'hffff;
               end
            end
         end
         FB_DEMAG: begin
            n.tdm = s_reg.tdm + 16'h0001;
            if (fb_fall) begin
               // Sample valid at every demag end, whatever the demag interval
               n.tdm_last = s_reg.tdm;
               n.meas.vout = 16'((32'(samp.valley_detect_input) *
                                  32'(s_reg.cfg[C_VGAIN])) >> 8) +
                             s_reg.cfg[C_VOFF];
               n.meas.vout_valid = 1'b1;
               n.st = FB_RING;
               n.vcnt = 4'h0;
            end
         end
         FB_RING: begin
            if (fb_rise) begin
               n.vcnt = s_reg.vcnt + 4'h1;
               if (s_reg.armed && s_reg.en && s_reg.vcnt + 4'h1 >= tgt) begin
                  n.st = FB_ON;
                  n.gate = 1'b1;
                  n.armed = 1'b0;
                  n.ton = 16'h0000;
                  n.tsw = 16'h0000;
                  num = 64'(s_reg.ipk) * 64'(s_reg.cfg[C_IGAIN]) * 64'(s_reg.tdm_last);
                  if (s_reg.mode == MODE_BURST) begin
                     num = num * 64'(s_reg.cfg[C_NPULSE]);
                     den = 64'(s_reg.cfg[C_TBURST]) << 1;
                  end else begin
                     den = 64'(s_reg.tsw) << 1;
                  end
                  n.meas.iout = (den == 64'h0000_0000_0000_0000) ? 16'hffff :
                                16'((num / den) >> 8);
                  n.meas.iout_valid = 1'b1;
               end
            end
            if (!s_reg.en) begin
               n.st = FB_IDLE;
            end
         end
         default: begin
            n.st = FB_IDLE;
            n.gate = 1'b0;
         end
      endcase
      s_next = n;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
         s_reg.vdly <= VDLY_RST;
         s_reg.cfg <= {NCFG{CFG_RST}};
         s_reg.mode <= MODE_FIRST;
         s_reg.st <= FB_IDLE;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign fault_flags = s_reg.flags;
   assign pfc_stop = s_reg.pfc_stop;
   assign fb_start_ok = s_reg.start_ok;
   assign fb_gate = s_reg.gate;
   assign fb_first_level_overcurrent_level = s_reg.cfg[C_FIRST_LEVEL_OVERCURRENT][9:0];
   assign meas = s_reg.meas;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   a_bus_uv_blank: assert property ($rose(s_reg.flags[F_BUS_UV]) |->
      $past(s_reg.cnt[F_BUS_UV] > s_reg.cfg[C_BLANK0 + F_BUS_UV]))
      else $error("bus under-voltage flag set before blanking expired");
   a_ov1_stops_pfc: assert property ($rose(s_reg.flags[F_BUS_OV1]) |-> s_reg.pfc_stop)
      else $error("first bus over-voltage did not stop PFC");
   a_pfc_resume_level: assert property ($fell(s_reg.pfc_stop) |->
      $past(samp.bus_sense_input < s_reg.cfg[C_BUS_REENTRY][11:0]))
      else $error("PFC resumed above re-entry level");
   a_ov2_fixed_level: assert property ($rose(s_reg.flags[F_BUS_OV2]) |->
      $past(samp.bus_sense_input) >= BUS_OV2_CODE)
      else $error("second bus over-voltage below fixed level");
   a_blank_restart: assert property (clk_en && !cond[F_CCM] |=> s_reg.cnt[F_CCM] == 16'h0000)
      else $error("blanking timer not restarted");
   a_ccm_startup_ok: assert property (clk_en && s_reg.ss_active |=>
      s_reg.cnt[F_CCM] == 16'h0000)
      else $error("conduction timer runs during soft start");
   a_ss_timeout: assert property (clk_en && s_reg.en && s_reg.ss_active && !ss_begin &&
      !ss_end && s_reg.ss_cnt >= s_reg.cfg[C_SS_MAX] |=>
      s_reg.flags[F_SS] && !s_reg.ss_active)
      else $error("soft start timeout not flagged");
   a_gate_first_level_overcurrent_off: assert property (clk_en && s_reg.st == FB_ON &&
      samp.flyback_current_sense_input >= s_reg.cfg[C_FIRST_LEVEL_OVERCURRENT][9:0] |=> !s_reg.gate)
      else $error("gate not off at overcurrent level");
   a_sense_sample: assert property ($fell(s_reg.gate) |->
      s_reg.vcs_sh == $past(s_reg.dly[SH_DEPTH-1]))
      else $error("sense sample not taken before turn-off");
   a_delayed_valley: assert property ($rose(s_reg.gate) && $past(s_reg.mode) == MODE_DELAYED &&
      $past(s_reg.st) == FB_RING |-> $past(s_reg.vcnt) >= 4'h1)
      else $error("delayed mode turned on at first valley");
endmodule
`default_nettype wire

/* File: verification/pfs_stage_model.sv */
// Purpose: Flyback power stage stand-in: shunt ramp, aux comparator, aux voltage
// Assumes: Follows fb_gate on the controller clock
// Notes: Demag 300 cycles, ringing valley every 100 cycles, eight valleys
`default_nettype none
module pfs_stage_model (
   // Clock
   input wire logic clock,
   // From controller
   input wire logic fb_gate,
   // To controller, valley count to the bench
   output logic [9:0] fb_cs,
   output logic fb_cmp,
   output logic [9:0] vd,
   output logic [3:0] valleys
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph = 5000;
   initial begin
      fb_cs = 10'h000;
      fb_cmp = 1'b0;
      vd = 10'h0f0;
      valleys = 4'h0;
   end
   always @(posedge clock) begin
      fb_cs <= fb_gate ? fb_cs + 10'h004 : 10'h000;
      ph <= fb_gate ? 0 : (ph < 5000 ? ph + 1 : ph);
      // Demag well over two microseconds
      fb_cmp <= (ph >= 1 && ph <= 300) ||
         (ph > 300 && ph < 1100 && (ph - 300) % 100 >= 50);
      // Aux level held past demag end, then changes every cycle until ph stops at 5000
      vd <= (ph >= 1 && ph <= 310) ? 10'h155 : (ph[0] ? 10'h2aa : 10'h0f0);
      if (fb_gate) begin
         valleys <= 4'h0;
      end else if (ph > 300 && ph < 1100 && (ph - 300) % 100 == 49) begin
         valleys <= valleys + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: verification/pfs_top_tb.sv */
// Purpose: Self-checking bench of pfs_top
// Assumes: Stage model drives flyback sense and aux comparator
// Notes: Blanking checks allow one tick of phase error
`default_nettype none
module pfs_top_tb import pfs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [11:0] bus = 12'hc00;
   logic [11:0] line = 12'h500;
   logic [9:0] pcs = 10'h000;
   logic [9:0] fb_cs, vd;
   logic [3:0] valleys;
   logic fb_cmp, pfc_stop, fb_start_ok, fb_gate;
   logic ss_begin = 1'b0;
   logic ss_end = 1'b0;
   logic fb_turn_on_req = 1'b0;
   logic pto = 1'b0;
   logic pval = 1'b0;
   logic [NF-1:0] fault_clr = 11'h000;
   logic [NF-1:0] fault_flags;
   logic [9:0] fb_first_level_overcurrent_level;
   pfs_samp_s samp;
   pfs_meas_s meas;
   int n_errors = 0;
   int compares = 0;
   int ton;
   logic [31:0] rv;
   // Config index in [23:16], value in [15:0]
   localparam logic [31:0] CFG_TAB [15] = '{32'h0000_0400, 32'h0001_0d00, 32'h0002_0ca0,
      32'h0003_0100, 32'h0004_0fff, 32'h0005_0100, 32'h0006_0f00, 32'h0007_ffff,
      32'h0009_ffff, 32'h000a_0002, 32'h0014_0003, 32'h0015_0200, 32'h0018_0100,
      32'h0019_0100, 32'h001a_0010};

   assign samp = '{bus, line, pcs, fb_cs, vd};

   pfs_top dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .samp(samp), .pfc_valley_cmp(pval), .fb_valley_cmp(fb_cmp), .pfc_turn_on(1'b0),
      .pfc_timeout_on(pto), .ss_begin(ss_begin), .ss_end(ss_end),
      .fb_turn_on_req(fb_turn_on_req), .fault_clr(fault_clr), .fault_flags(fault_flags),
      .pfc_stop(pfc_stop), .fb_start_ok(fb_start_ok), .fb_gate(fb_gate),
      .fb_first_level_overcurrent_level(fb_first_level_overcurrent_level), .meas(meas));

   pfs_stage_model stage (.clock(clock), .fb_gate(fb_gate), .fb_cs(fb_cs),
      .fb_cmp(fb_cmp), .vd(vd), .valleys(valleys));

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic at(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask

   task automatic req();
      @(posedge clock);
      fb_turn_on_req <= 1'b1;
      @(posedge clock);
      fb_turn_on_req <= 1'b0;
      #1;
   endtask

   task automatic wait_for(input logic v, output int n);
      for (n = 0; n < 3000 && fb_gate !== v; n++) at(1);
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      at(1);
      rd(A_CTRL);
      chk(rv, 32'h0000_0020);
      rd(8'hfc);
      chk(rv, 32'h0);
      rd(A_CFG_BASE);
      chk(rv, 32'h0);
      chk(fault_flags, 11'h000);
      foreach (CFG_TAB[k]) wr(A_CFG_BASE + {CFG_TAB[k][21:16], 2'b00}, CFG_TAB[k] & 32'hffff);
      wr(A_CTRL, 32'h1);
      rd(A_CFG_BASE);
      chk(rv, 32'h400);
      at(2);
      chk(fb_start_ok, 1'h1);
      chk(fault_flags, 11'h000);
      $display("test setup done");
      // Interrupted under-voltage, then a long one
      @(posedge clock) bus <= 12'h300;
      at(150);
      @(posedge clock) bus <= 12'hc00;
      at(2);
      @(posedge clock) bus <= 12'h300;
      at(150);
      chk(fault_flags, 11'h000);
      at(250);
      chk(fault_flags, 11'h001);
      @(posedge clock) bus <= 12'hc00;
      wr(A_FAULT, 32'h7ff);
      at(1);
      chk(fault_flags, 11'h000);
      $display("test bus low done");
      // First over-voltage limit stops switching until re-entry
      @(posedge clock) bus <= 12'hd80;
      at(250);
      chk(pfc_stop, 1'h1);
      chk(fault_flags[F_BUS_OV1], 1'h1);
      @(posedge clock) bus <= 12'hcc0;
      at(50);
      chk(pfc_stop, 1'h1);
      @(posedge clock) bus <= 12'hc80;
      at(5);
      chk(pfc_stop, 1'h0);
      $display("test bus high done");
      // Fixed second limit at seven sixths of reference
      @(posedge clock) bus <= 12'hdff;
      at(400);
      chk(fault_flags[F_BUS_OV2], 1'h0);
      @(posedge clock) bus <= 12'he00;
      at(250);
      chk(fault_flags[F_BUS_OV2], 1'h1);
      // Open shunt drives PFC sense high
      @(posedge clock) pcs <= 10'h3bf;
      at(300);
      chk(fault_flags[F_SECOND_LEVEL_OVERCURRENT], 1'h0);
      @(posedge clock) pcs <= 10'h3c0;
      at(250);
      chk(fault_flags[F_SECOND_LEVEL_OVERCURRENT], 1'h1);
      @(posedge clock) pcs <= 10'h000;
      @(posedge clock) bus <= 12'hc00;
      wr(A_FAULT, 32'h7ff);
      $display("test fixed limits done");
      // Soft start timeout, then clear by port
      @(posedge clock) ss_begin <= 1'b1;
      @(posedge clock) ss_begin <= 1'b0;
      at(150);
      chk(fault_flags[F_SS], 1'h0);
      at(300);
      chk(fault_flags[F_SS], 1'h1);
      @(posedge clock) ss_end <= 1'b1;
      @(posedge clock) ss_end <= 1'b0;
      @(posedge clock) fault_clr <= 11'h400;
      @(posedge clock) fault_clr <= 11'h000;
      at(2);
      chk(fault_flags, 11'h000);
      $display("test soft start done");
      // Forced turn-on with no valley ringing
      @(posedge clock) pto <= 1'b1;
      @(posedge clock) pto <= 1'b0;
      at(250);
      chk(fault_flags[F_CCM], 1'h1);
      rd(A_STATUS);
      chk(rv, 32'h0000_0102);
      @(posedge clock) pval <= 1'b1;
      at(4);
      wr(A_FAULT, 32'h7ff);
      at(1);
      chk(fault_flags, 11'h000);
      $display("test conduction done");
      // Flyback pulses in first-valley then delayed-valley mode
      req();
      wait_for(1'b1, ton);
      req();
      wait_for(1'b0, ton);
      chk(ton >= 115 && ton <= 136, 1'h1);
      chk(fb_first_level_overcurrent_level, 10'h200);
      rd(A_IPK);
      chk(rv, 32'h0000_01f0);
      wait_for(1'b1, ton);
      chk(valleys, 4'h1);
      chk(meas.vout, 16'h0165);
      wr(A_CTRL, 32'h33);
      req();
      wait_for(1'b0, ton);
      wait_for(1'b1, ton);
      chk(valleys, 4'h3);
      $display("test flyback done");
      close_out();
   end
endmodule
`default_nettype wire
